// >>> core/itu_top.v
// Purpose: Interrupt triggered transfer unit with APB registers
// Assumes: Memory bus is a simple req/ack master on the same clock
// Notes: Descriptor state is not written back to memory
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/10ps
`include "itu_defs.vh"
module itu_top (
  input wire clk_in,
  input wire resetn_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [7:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg pready_out,
  output reg [31:0] prdata_out,
  output reg pslverr_out,
  input wire [7:0] src_req_in,
  input wire module_stop_in,
  output reg [7:0] src_ack_out,
  output reg mem_req_out,
  output reg mem_we_out,
  output reg [31:0] mem_addr_out,
  output reg [31:0] mem_wdata_out,
  input wire mem_ack_in,
  input wire [31:0] mem_rdata_in,
  output reg irq_out
);
  localparam S_IDLE = 3'h0;
  localparam S_PTR = 3'h1;
  localparam S_DESC = 3'h2;
  localparam S_RD = 3'h3;
  localparam S_WR = 3'h4;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  wire [7:0] req_s;
  wire stop_s;

  itu_sync #(.W(8)) u_req_sync (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .d_in(src_req_in),
    .q_out(req_s)
  );

  itu_sync #(.W(1)) u_stop_sync (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .d_in(module_stop_in),
    .q_out(stop_s)
  );

  // ----------------------------------------------------------------
  // Registers and engine state
  // ----------------------------------------------------------------
  reg skip_en_q, full_q, seq_en_q;
  reg [31:0] vbr_q, ibr_q;
  reg [7:0] act_en_q;
  reg [1:0] istat_q, imask_q;
  reg seq_go_q, cabt_q, sabt_q;
  reg [7:0] seq_num_q;
  reg [2:0] state_q;
  reg busy_q, seq_q, held_q;
  reg [7:0] vec_q, held_vec_q;
  reg [31:0] ptr_q, cfg_q, src_q, dst_q, src0_q, dst0_q, data_q;
  reg [15:0] cnt_q, cnt0_q;
  reg [7:0] blk_q;
  reg [1:0] widx_q;
  reg [1:0] ev_set;

  wire [31:0] src_addr, dst_addr;

  itu_addr_form u_src_form (
    .full_in(full_q),
    .raw_in(src_q),
    .addr_out(src_addr)
  );

  itu_addr_form u_dst_form (
    .full_in(full_q),
    .raw_in(dst_q),
    .addr_out(dst_addr)
  );

  // ----------------------------------------------------------------
  // APB slave: one wait state, read data and error registered
  // ----------------------------------------------------------------
  wire apb_setup = psel_in & penable_in & ~pready_out;
  wire apb_wr = psel_in & penable_in & pready_out & pwrite_in;
  reg [31:0] rd_mux;
  reg rd_err;

  always @* begin
    rd_mux = `ITU_RST_32;
    rd_err = 1'b0;
    case (paddr_in)
      `ITU_A_CTRL: begin
        rd_mux[`ITU_C_SKIP] = skip_en_q;
        rd_mux[`ITU_C_FULL] = full_q;
        rd_mux[`ITU_C_SEQEN] = seq_en_q;
      end
      `ITU_A_VBR: rd_mux = vbr_q;
      `ITU_A_IBR: rd_mux = ibr_q;
      `ITU_A_ACTEN: rd_mux[7:0] = act_en_q;
      `ITU_A_STAT: begin
        rd_mux[`ITU_S_BUSY] = busy_q;
        rd_mux[`ITU_S_HELD] = held_q;
        rd_mux[`ITU_S_SEQ] = seq_q;
        rd_mux[`ITU_S_VEC] = vec_q;
      end
      `ITU_A_ISTAT: rd_mux[1:0] = istat_q;
      `ITU_A_IMASK: rd_mux[1:0] = imask_q;
      `ITU_A_SEQ: rd_mux[`ITU_SEQ_NUM] = seq_num_q;
      default: rd_err = 1'b1;
    endcase
  end

  always @(posedge clk_in) begin
    if (!resetn_in) begin
      pready_out <= 1'b0;
      prdata_out <= `ITU_RST_32;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= apb_setup;
      prdata_out <= apb_setup ? (pwrite_in ? `ITU_RST_32 : rd_mux) : `ITU_RST_32;
      pslverr_out <= apb_setup & rd_err;
    end
  end

  // ----------------------------------------------------------------
  // Software registers and interrupt status
  // ----------------------------------------------------------------
  wire wr_ctrl = apb_wr & (paddr_in == `ITU_A_CTRL);
  wire wr_seq = apb_wr & (paddr_in == `ITU_A_SEQ);
  wire seq_take;
  wire act_end;

  always @(posedge clk_in) begin
    if (!resetn_in) begin
      skip_en_q <= 1'b0;
      full_q <= 1'b0;
      seq_en_q <= 1'b0;
      vbr_q <= `ITU_RST_32;
      ibr_q <= `ITU_RST_32;
      act_en_q <= 8'h00;
      istat_q <= 2'h0;
      imask_q <= 2'h0;
      seq_go_q <= 1'b0;
      seq_num_q <= 8'h00;
      cabt_q <= 1'b0;
      sabt_q <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        skip_en_q <= pwdata_in[`ITU_C_SKIP];
        full_q <= pwdata_in[`ITU_C_FULL];
        seq_en_q <= pwdata_in[`ITU_C_SEQEN];
      end
      // Table base keeps only 1 Kbyte aligned bits
      if (apb_wr & (paddr_in == `ITU_A_VBR))
        vbr_q <= pwdata_in & `ITU_VBR_MASK;
      if (apb_wr & (paddr_in == `ITU_A_IBR))
        ibr_q <= pwdata_in;
      if (apb_wr & (paddr_in == `ITU_A_ACTEN))
        act_en_q <= pwdata_in[7:0];
      if (apb_wr & (paddr_in == `ITU_A_IMASK))
        imask_q <= pwdata_in[1:0];
      // Hardware set wins over write-one-to-clear
      istat_q <= (istat_q & ~((apb_wr & (paddr_in == `ITU_A_ISTAT)) ?
        pwdata_in[1:0] : 2'h0)) | ev_set;
      irq_out <= |(istat_q & imask_q);
      // Sequence request: abort or disable drops a waiting request
      if (wr_seq & seq_en_q) begin
        seq_go_q <= 1'b1;
        seq_num_q <= pwdata_in[`ITU_SEQ_NUM];
      end else if (seq_take | (wr_ctrl & (pwdata_in[`ITU_C_SABT] |
        ~pwdata_in[`ITU_C_SEQEN]))) begin
        seq_go_q <= 1'b0;
      end
      // Abort flags live only while an activation runs
      // An abort that meets the end of the activation must not outlive it
      if (wr_ctrl & pwdata_in[`ITU_C_CABT] & busy_q & ~act_end)
        cabt_q <= 1'b1;
      else if (act_end)
        cabt_q <= 1'b0;
      if (wr_ctrl & pwdata_in[`ITU_C_SABT] & busy_q & seq_q & ~act_end)
        sabt_q <= 1'b1;
      else if (act_end)
        sabt_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Activation selection: lowest enabled requesting source
  // ----------------------------------------------------------------
  wire [7:0] pend = req_s & act_en_q & ~src_ack_out;
  reg [7:0] pick;
  reg pick_v;
  integer i;

  always @* begin
    pick = 8'h00;
    pick_v = 1'b0;
    for (i = 7; i >= 0; i = i - 1) begin
      if (pend[i]) begin
        pick = i[7:0];
        pick_v = 1'b1;
      end
    end
  end

  // Stop holds the unit at the idle boundary
  wire start_ok = (state_q == S_IDLE) & ~stop_s;
  wire act_take = start_ok & pick_v;
  assign seq_take = start_ok & ~pick_v & seq_go_q & seq_en_q;
  wire reuse = skip_en_q & held_q & (held_vec_q == pick);
  wire [1:0] last_w = full_q ? `ITU_LAST_F : `ITU_LAST_C;
  wire [31:0] dsz = full_q ? `ITU_DSZ_F : `ITU_DSZ_C;
  wire [7:0] blk_ld = ((cfg_q[`ITU_D_MODE] == `ITU_MD_BLK) &&
    (cfg_q[`ITU_D_BLK] != 8'h00)) ? cfg_q[`ITU_D_BLK] : 8'h01;
  wire [15:0] cnt_nx = cnt_q - 16'h0001;
  wire blk_done = (blk_q == 8'h01);
  wire chain_go = cfg_q[`ITU_D_CHAIN] & ~cabt_q & ~sabt_q;
  assign act_end = (state_q == S_WR) & mem_ack_in & blk_done & ~chain_go;

  always @* begin
    ev_set = 2'h0;
    if ((state_q == S_WR) & mem_ack_in & blk_done) begin
      // Per-transfer or count-exhausted CPU interrupt
      ev_set[`ITU_EV_CPU] = cfg_q[`ITU_D_EACH] |
        ((cnt_nx == 16'h0000) & (cfg_q[`ITU_D_MODE] != `ITU_MD_RPT));
      ev_set[`ITU_EV_DONE] = ~chain_go;
    end
  end

  // ----------------------------------------------------------------
  // Transfer engine (memory bus master)
  // ----------------------------------------------------------------
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      state_q <= S_IDLE;
      busy_q <= 1'b0;
      seq_q <= 1'b0;
      held_q <= 1'b0;
      held_vec_q <= 8'h00;
      vec_q <= 8'h00;
      src_ack_out <= 8'h00;
      ptr_q <= `ITU_RST_32;
      cfg_q <= `ITU_RST_32;
      src_q <= `ITU_RST_32;
      dst_q <= `ITU_RST_32;
      src0_q <= `ITU_RST_32;
      dst0_q <= `ITU_RST_32;
      data_q <= `ITU_RST_32;
      cnt_q <= 16'h0000;
      cnt0_q <= 16'h0000;
      blk_q <= 8'h00;
      widx_q <= 2'h0;
      mem_req_out <= 1'b0;
      mem_we_out <= 1'b0;
      mem_addr_out <= `ITU_RST_32;
      mem_wdata_out <= `ITU_RST_32;
    end else begin
      src_ack_out <= 8'h00;
      if (mem_req_out & mem_ack_in)
        mem_req_out <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (act_take) begin
            busy_q <= 1'b1;
            seq_q <= 1'b0;
            vec_q <= pick;
            src_ack_out <= 8'h01 << pick[2:0];
            mem_req_out <= 1'b1;
            mem_we_out <= 1'b0;
            if (reuse) begin
              // Held descriptor reused, no fetch
              blk_q <= blk_ld;
              mem_addr_out <= src_addr;
              state_q <= S_RD;
            end else begin
              held_q <= 1'b0;
              mem_addr_out <= vbr_q + {22'h000000, pick, 2'h0};
              state_q <= S_PTR;
            end
          end else if (seq_take) begin
            // Sequence pointer from the index table
            busy_q <= 1'b1;
            seq_q <= 1'b1;
            held_q <= 1'b0;
            mem_req_out <= 1'b1;
            mem_we_out <= 1'b0;
            mem_addr_out <= ibr_q + {22'h000000, seq_num_q, 2'h0};
            state_q <= S_PTR;
          end
        end
        S_PTR: begin
          if (mem_ack_in) begin
            ptr_q <= mem_rdata_in;
            widx_q <= 2'h0;
            mem_req_out <= 1'b1;
            mem_addr_out <= mem_rdata_in;
            state_q <= S_DESC;
          end
        end
        S_DESC: begin
          if (mem_ack_in) begin
            // Word 0 config, word 1 source, word 2 destination
            case (widx_q)
              2'h0: begin
                cfg_q <= mem_rdata_in;
                cnt_q <= mem_rdata_in[`ITU_D_CNT];
                cnt0_q <= mem_rdata_in[`ITU_D_CNT];
              end
              2'h1: begin
                src_q <= mem_rdata_in;
                src0_q <= mem_rdata_in;
              end
              2'h2: begin
                dst_q <= mem_rdata_in;
                dst0_q <= mem_rdata_in;
              end
              default: begin
              end
            endcase
            mem_req_out <= 1'b1;
            if (widx_q == last_w) begin
              // Three or four words per descriptor
              blk_q <= blk_ld;
              mem_addr_out <= src_addr;
              state_q <= S_RD;
            end else begin
              widx_q <= widx_q + 2'h1;
              mem_addr_out <= mem_addr_out + `ITU_WSTEP;
            end
          end
        end
        S_RD: begin
          if (mem_ack_in) begin
            data_q <= mem_rdata_in;
            mem_req_out <= 1'b1;
            mem_we_out <= 1'b1;
            mem_addr_out <= dst_addr;
            mem_wdata_out <= mem_rdata_in;
            state_q <= S_WR;
          end
        end
        S_WR: begin
          if (mem_ack_in) begin
            mem_we_out <= 1'b0;
            if (cfg_q[`ITU_D_SINC])
              src_q <= src_q + `ITU_WSTEP;
            if (cfg_q[`ITU_D_DINC])
              dst_q <= dst_q + `ITU_WSTEP;
            if (!blk_done) begin
              // Rest of the block in this activation
              blk_q <= blk_q - 8'h01;
              mem_req_out <= 1'b1;
              mem_addr_out <= cfg_q[`ITU_D_SINC] ? src_addr + `ITU_WSTEP : src_addr;
              state_q <= S_RD;
            end else begin
              cnt_q <= cnt_nx;
              if ((cnt_nx == 16'h0000) && (cfg_q[`ITU_D_MODE] == `ITU_MD_RPT)) begin
                // Repeat mode reloads count and start addresses
                cnt_q <= cnt0_q;
                src_q <= src0_q;
                dst_q <= dst0_q;
              end
              if (chain_go) begin
                // Next descriptor follows contiguously
                ptr_q <= ptr_q + dsz;
                widx_q <= 2'h0;
                mem_req_out <= 1'b1;
                mem_addr_out <= ptr_q + dsz;
                state_q <= S_DESC;
              end else begin
                // One activation finishes before the next starts
                busy_q <= 1'b0;
                held_q <= ~seq_q & ~cfg_q[`ITU_D_CHAIN];
                held_vec_q <= vec_q;
                state_q <= S_IDLE;
              end
            end
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule

// >>> core/itu_defs.vh
// Purpose: Constants for the interrupt triggered transfer unit
// Assumes: 32-bit APB register window, one word per register
// Notes: Included by itu_top, itu_addr_form, the checker and the testbench
`ifndef ITU_DEFS_VH
`define ITU_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ITU_A_CTRL 8'h00
`define ITU_A_VBR 8'h04
`define ITU_A_IBR 8'h08
`define ITU_A_ACTEN 8'h0C
`define ITU_A_STAT 8'h10
`define ITU_A_ISTAT 8'h14
`define ITU_A_IMASK 8'h18
`define ITU_A_SEQ 8'h1C

// ----------------------------------------------------------------
// Control and status fields
// ----------------------------------------------------------------
`define ITU_C_SKIP 0
`define ITU_C_FULL 1
`define ITU_C_SEQEN 2
`define ITU_C_CABT 3
`define ITU_C_SABT 4
`define ITU_S_BUSY 0
`define ITU_S_HELD 1
`define ITU_S_SEQ 2
`define ITU_S_VEC 15:8
`define ITU_EV_CPU 0
`define ITU_EV_DONE 1
`define ITU_SEQ_NUM 7:0
`define ITU_VBR_MASK 32'hFFFFFC00
`define ITU_RST_32 32'h00000000

// ----------------------------------------------------------------
// Descriptor layout (word 0 holds the configuration)
// ----------------------------------------------------------------
`define ITU_D_MODE 1:0
`define ITU_D_CHAIN 2
`define ITU_D_EACH 3
`define ITU_D_SINC 4
`define ITU_D_DINC 5
`define ITU_D_BLK 15:8
`define ITU_D_CNT 31:16
`define ITU_MD_NORM 2'h0
`define ITU_MD_RPT 2'h1
`define ITU_MD_BLK 2'h2
`define ITU_LAST_C 2'h2
`define ITU_LAST_F 2'h3
`define ITU_DSZ_C 32'h0000000C
`define ITU_DSZ_F 32'h00000010
`define ITU_WSTEP 32'h00000004
`define ITU_CMP_SIGN 23

`endif

// >>> core/itu_sync.v
// Purpose: Two flip-flop level synchroniser
// Assumes: Inputs are slow levels from outside the clock domain
// Notes: First stage feeds only the second stage
`timescale 1ns/10ps
module itu_sync #(
  parameter W = 1
) (
  input wire clk_in,
  input wire resetn_in,
  input wire [W-1:0] d_in,
  output reg [W-1:0] q_out
);
  reg [W-1:0] meta_q;

  always @(posedge clk_in) begin
    if (!resetn_in) begin
      meta_q <= {W{1'b0}};
      q_out <= {W{1'b0}};
    end else begin
      meta_q <= d_in;
      q_out <= meta_q;
    end
  end
endmodule

// >>> core/itu_addr_form.v
// Purpose: Forms a 32-bit bus address from a stored descriptor address
// Assumes: Compact mode keeps 24 significant bits
// Notes: Compact mode reaches only the lowest and highest 8 Mbyte
`timescale 1ns/10ps
`include "itu_defs.vh"
module itu_addr_form (
  input wire full_in,
  input wire [31:0] raw_in,
  output wire [31:0] addr_out
);
  // Sign extension from bit 23 in compact mode
  assign addr_out = full_in ? raw_in :
    {{8{raw_in[`ITU_CMP_SIGN]}}, raw_in[`ITU_CMP_SIGN:0]};
endmodule

// >>> tb/itu_assertions.sv
// Purpose: Port checker for the interrupt triggered transfer unit
// Assumes: Vector table base sits on a 1 Kbyte boundary
// Notes: Bound to itu_top after the module
`timescale 1ns/10ps
`include "itu_defs.vh"
module itu_chk (
  input wire clk_in,
  input wire resetn_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [7:0] paddr_in,
  input wire [31:0] pwdata_in,
  input wire pready_out,
  input wire [31:0] prdata_out,
  input wire pslverr_out,
  input wire [7:0] src_req_in,
  input wire module_stop_in,
  input wire [7:0] src_ack_out,
  input wire mem_req_out,
  input wire mem_we_out,
  input wire [31:0] mem_addr_out,
  input wire [31:0] mem_wdata_out,
  input wire mem_ack_in,
  input wire [31:0] mem_rdata_in,
  input wire irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // Mirror of the skip enable, as written over the register bus
  logic skip_q;
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      skip_q <= 1'b0;
    end else if (psel_in && penable_in && pready_out && pwrite_in &&
      paddr_in == `ITU_A_CTRL) begin
      skip_q <= pwdata_in[`ITU_C_SKIP];
    end
  end
  // ------------------------------------------------------------
  // Named steps
  // ------------------------------------------------------------
  sequence s_access_start;
    psel_in && $rose(penable_in);
  endsequence
  sequence s_taken;
    src_ack_out != 8'h00;
  endsequence
  sequence s_stopped;
    module_stop_in [*3];
  endsequence
  AST_APB_WAIT1: assert property (s_access_start |=> pready_out)
    else $error("ready not one cycle into access");
  AST_READY_PULSE: assert property (pready_out |=> !pready_out)
    else $error("ready longer than one cycle");
  AST_ERR_QUAL: assert property (pslverr_out |-> pready_out && prdata_out == 32'h00000000)
    else $error("error without ready or with data");
  AST_MEM_HOLD: assert property (mem_req_out && !mem_ack_in |=> mem_req_out
    && $stable(mem_addr_out) && $stable(mem_we_out) && $stable(mem_wdata_out))
    else $error("memory request changed before ack");
  AST_ACK_PULSE: assert property (s_taken |-> $onehot(src_ack_out) ##1 src_ack_out == 8'h00)
    else $error("source ack not a one-hot pulse");
  AST_ACK_CAUSE: assert property (s_taken |-> (src_ack_out & $past(src_req_in, 3)) == src_ack_out)
    else $error("source taken without request");
  AST_PTR_FETCH: assert property (s_taken |-> mem_req_out && !mem_we_out
    && (skip_q || (mem_addr_out[1:0] == 2'h0 && mem_addr_out[9:5] == 5'h00
    && src_ack_out[mem_addr_out[4:2]])))
    else $error("pointer read not at base plus four times vector");
  AST_STOP_HOLDS: assert property (s_stopped |=> src_ack_out == 8'h00)
    else $error("activation taken while stopped");
endmodule

bind itu_top itu_chk i_itu_chk (.clk_in, .resetn_in, .psel_in, .penable_in, .pwrite_in,
  .paddr_in, .pwdata_in, .pready_out, .prdata_out, .pslverr_out, .src_req_in, .module_stop_in,
  .src_ack_out, .mem_req_out, .mem_we_out, .mem_addr_out, .mem_wdata_out, .mem_ack_in,
  .mem_rdata_in, .irq_out);

// >>> tb/itu_mem_model.sv
// Purpose: System memory model answering the unit's bus requests
// Assumes: 4 Kbyte image, upper address bits ignored
// Notes: Latency set by lat_in; idle read data toggles every cycle
`timescale 1ns/10ps
module itu_mem_model (
  input wire clk_in,
  input wire [1:0] lat_in,
  input wire mem_req_in,
  input wire mem_we_in,
  input wire [31:0] mem_addr_in,
  input wire [31:0] mem_wdata_in,
  output reg mem_ack_out,
  output reg [31:0] mem_rdata_out
);
  reg [31:0] mem [0:1023];
  reg [1:0] wait_q;
  reg hi_seen;
  int acc_cnt;
  initial begin
    mem_ack_out = 1'b0;
    mem_rdata_out = 32'h00000000;
    wait_q = 2'h0;
    hi_seen = 1'b0;
    acc_cnt = 0;
  end
  always @(posedge clk_in) begin
    mem_ack_out <= 1'b0;
    mem_rdata_out <= ~mem_rdata_out;
    if (mem_req_in && !mem_ack_out) begin
      if (wait_q == lat_in) begin
        wait_q <= 2'h0;
        mem_ack_out <= 1'b1;
        acc_cnt <= acc_cnt + 1;
        if (mem_we_in) begin
          mem[mem_addr_in[11:2]] <= mem_wdata_in;
        end else begin
          mem_rdata_out <= mem[mem_addr_in[11:2]];
          if (mem_addr_in == 32'hFFFFF800) hi_seen <= 1'b1;
        end
      end else begin
        wait_q <= wait_q + 2'h1;
      end
    end
  end
endmodule

// >>> tb/testbench.sv
// Purpose: Self-checking bench for the transfer unit
// Assumes: Memory word at index k preloaded with D0000000 plus k
// Notes: Descriptors and pointers are laid out by the table below
`timescale 1ns/10ps
`include "itu_defs.vh"
module testbench;
  logic clk_in, resetn_in, psel, penable, pwrite, module_stop, err, mask_on;
  logic [7:0] paddr, src_req;
  logic [31:0] pwdata, rd;
  logic [1:0] lat;
  wire pready, pslverr, mem_req, mem_we, mem_ack, irq;
  wire [7:0] src_ack;
  wire [31:0] prdata, mem_addr, mem_wdata, mem_rdata;
  int error_cnt, samples_checked, cyc, acc0, k;
  // Pairs of byte address and word: pointers and descriptors
  localparam logic [31:0] TAB [0:53] = '{
    32'h408, 32'h500, 32'h500, 32'h00020030, 32'h504, 32'h600, 32'h508, 32'h700,
    32'h40C, 32'h520, 32'h520, 32'h0001000C, 32'h524, 32'h00FFF800, 32'h528, 32'h720,
    32'h52C, 32'h00010000, 32'h530, 32'h610, 32'h534, 32'h730,
    32'h410, 32'h540, 32'h540, 32'h00010000, 32'h544, 32'h620, 32'h548, 32'h740,
    32'h414, 32'h560, 32'h560, 32'h00010332, 32'h564, 32'h640, 32'h568, 32'h760,
    32'h418, 32'h580, 32'h580, 32'h00010001, 32'h584, 32'h650, 32'h588, 32'h770,
    32'h484, 32'h5A0, 32'h5A0, 32'h00010000, 32'h5A4, 32'h660, 32'h5A8, 32'h780};
  itu_top i_itu_top (.clk_in(clk_in), .resetn_in(resetn_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .pready_out(pready), .prdata_out(prdata), .pslverr_out(pslverr), .src_req_in(src_req),
    .module_stop_in(module_stop), .src_ack_out(src_ack), .mem_req_out(mem_req),
    .mem_we_out(mem_we), .mem_addr_out(mem_addr), .mem_wdata_out(mem_wdata),
    .mem_ack_in(mem_ack), .mem_rdata_in(mem_rdata), .irq_out(irq));
  itu_mem_model i_itu_mem_model (.clk_in(clk_in), .lat_in(lat), .mem_req_in(mem_req),
    .mem_we_in(mem_we), .mem_addr_in(mem_addr), .mem_wdata_in(mem_wdata),
    .mem_ack_out(mem_ack), .mem_rdata_out(mem_rdata));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // Sources drop their request once taken; hang guard
  always @(posedge clk_in) begin
    if (|src_ack) src_req <= src_req & ~src_ack;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict;
    end
  end
  task give_verdict;
    $display("TB: checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // ------------------------------------------------------------
  // APB transfer: setup, access until ready, one idle cycle
  // ------------------------------------------------------------
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_in);
    if (n == 50) chk("apb_ready", 32'h0, 32'h1);
  endtask
  task fire(input int i);
    acc0 = i_itu_mem_model.acc_cnt;
    src_req[i] <= 1'b1;
    @(posedge clk_in);
  endtask
  task finish(input int exp_acc, input logic [31:0] exp_ist);
    int n;
    n = 0;
    while (i_itu_mem_model.acc_cnt < acc0 + exp_acc && n < 500) begin
      @(posedge clk_in);
      n++;
    end
    apb(1'b0, `ITU_A_STAT, 32'h0);
    chk("busy", {31'h0, rd[0]}, 32'h0);
    chk("accesses", i_itu_mem_model.acc_cnt - acc0, exp_acc);
    apb(1'b0, `ITU_A_ISTAT, 32'h0);
    chk("istat", rd, exp_ist);
    chk("irq", {31'h0, irq}, {31'h0, mask_on});
    apb(1'b1, `ITU_A_ISTAT, 32'h3);
  endtask
  task move(input logic [31:0] s, input logic [31:0] d);
    chk("dst", i_itu_mem_model.mem[d[11:2]], 32'hD0000000 | s[11:2]);
  endtask
  initial begin
    {psel, penable, pwrite, module_stop, resetn_in, mask_on} = 6'h00;
    {paddr, src_req, pwdata, lat} = 50'h0;
    {error_cnt, samples_checked, cyc, acc0} = '0;
    for (k = 0; k < 1024; k++) i_itu_mem_model.mem[k] = 32'hD0000000 | k;
    for (k = 0; k < 54; k += 2) i_itu_mem_model.mem[TAB[k][11:2]] = TAB[k + 1];
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    for (k = 0; k < 8; k++) begin
      apb(1'b0, 8'(4 * k), 32'h0);
      chk("reset", rd, `ITU_RST_32);
    end
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped_err", {31'h0, err}, 32'h1);
    chk("unmapped_rd", rd, 32'h0);
    apb(1'b1, `ITU_A_STAT, 32'hFF);
    apb(1'b0, `ITU_A_STAT, 32'h0);
    chk("stat_ro", rd, 32'h0);
    apb(1'b1, `ITU_A_VBR, 32'h000005FF);
    apb(1'b0, `ITU_A_VBR, 32'h0);
    chk("vbr", rd, 32'h00000400);
    apb(1'b1, `ITU_A_ACTEN, 32'h7C);
    fire(1);
    fire(2);
    finish(6, 32'h2);
    move(32'h600, 32'h700);
    apb(1'b1, `ITU_A_IMASK, 32'h2);
    mask_on = 1'b1;
    apb(1'b1, `ITU_A_CTRL, 32'h1);
    fire(2);
    finish(2, 32'h3);
    move(32'h604, 32'h704);
    apb(1'b1, `ITU_A_CTRL, 32'h0);
    fire(3);
    finish(11, 32'h3);
    move(32'h800, 32'h720);
    move(32'h610, 32'h730);
    chk("high_region", {31'h0, i_itu_mem_model.hi_seen}, 32'h1);
    apb(1'b1, `ITU_A_CTRL, 32'h2);
    module_stop <= 1'b1;
    fire(4);
    repeat (20) @(posedge clk_in);
    chk("stopped", i_itu_mem_model.acc_cnt - acc0, 32'h0);
    module_stop <= 1'b0;
    finish(7, 32'h3);
    move(32'h620, 32'h740);
    apb(1'b1, `ITU_A_CTRL, 32'h0);
    fire(5);
    finish(10, 32'h3);
    for (k = 0; k < 3; k++) move(32'h640 + 4 * k, 32'h760 + 4 * k);
    fire(6);
    finish(6, 32'h2);
    move(32'h650, 32'h770);
    apb(1'b1, `ITU_A_IBR, 32'h480);
    apb(1'b1, `ITU_A_CTRL, 32'h4);
    acc0 = i_itu_mem_model.acc_cnt;
    apb(1'b1, `ITU_A_SEQ, 32'h1);
    finish(6, 32'h3);
    move(32'h660, 32'h780);
    apb(1'b1, `ITU_A_CTRL, 32'h0);
    acc0 = i_itu_mem_model.acc_cnt;
    apb(1'b1, `ITU_A_SEQ, 32'h1);
    repeat (20) @(posedge clk_in);
    chk("seq_off", i_itu_mem_model.acc_cnt - acc0, 32'h0);
    lat <= 2'h3;
    fire(3);
    while (mem_req !== 1'b1) @(posedge clk_in);
    apb(1'b0, `ITU_A_STAT, 32'h0);
    chk("stat_run", {16'h0, rd[15:8], 7'h0, rd[0]}, 32'h00000301);
    apb(1'b1, `ITU_A_CTRL, 32'h8);
    finish(6, 32'h3);
    @(posedge clk_in);
    chk("irq_clear", {31'h0, irq}, 32'h0);
    give_verdict;
  end
endmodule
